// ---- verilog/sdam_alarm_mgr.sv ----
// servo drive alarm manager: detection, classes, reset, display
`timescale 1ns/10ps
`default_nettype none
`include "sdam_regs.svh"

module sdam_alarm_mgr #(
	parameter int unsigned LOCK_CYCLES    = `SDAM_LOCK_TIME_MS * (`SDAM_CLK_HZ / `SDAM_HZ_PER_KHZ),
	parameter int unsigned ENC_FAIL_LIMIT = 3
) (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	// pins from outside the clock domain
	input  wire logic        ESTOP_OPEN_I,
	input  wire logic        FWD_TRAVEL_INHIBIT_OPEN_I,
	input  wire logic        REV_TRAVEL_INHIBIT_OPEN_I,
	input  wire logic        INDEX_PULSE_I,
	input  wire logic [7:0]  NODE_ADDR_I,
	// monitor values and settings
	input  wire logic [31:0] DEVIATION_CNT_I,
	input  wire logic [31:0] DEVIATION_OVERFLOW_LEVEL_I,
	input  wire logic [15:0] MOTOR_SPEED_I,
	input  wire logic [15:0] OVERSPEED_DETECT_LEVEL_I,
	input  wire logic [31:0] INTERNAL_DEV_CNT_I,
	input  wire logic [31:0] OVERRUN_DISTANCE_I,
	input  wire logic [31:0] OVERRUN_RANGE_SETTING_I,
	input  wire logic [23:0] INDEX_TIMEOUT_I,
	input  wire logic        OVERLOAD_TRIP_I,
	input  wire logic        OVERLOAD_NEAR_I,
	input  wire logic [1:0]  MPU_FAULT_I,
	// power-on parameter check
	input  wire logic        PARAM_CHECK_DONE_I,
	input  wire logic        PARAM_DATA_BAD_I,
	input  wire logic        PARAM_VERIFY_BAD_I,
	// encoder and fieldbus events
	input  wire logic        ENC_COMM_FAIL_I,
	input  wire logic        ENC_COMM_OK_I,
	input  wire logic        RX_FAIL_I,
	input  wire logic        RX_OK_I,
	input  wire logic [7:0]  COMM_RETRY_LIMIT_I,
	input  wire logic        LINK_ACTIVE_I,
	input  wire logic        CYCLE_TICK_I,
	input  wire logic        SYNC_FRAME_I,
	input  wire logic        ASYNC_MODE_I,
	input  wire logic        SYNC_CMD_I,
	input  wire logic        NET_ERROR_I,
	// reset requests
	input  wire logic        RESET_BUS_I,
	input  wire logic        RESET_TOOL_I,
	input  wire logic        RESET_PANEL_I,
	input  wire logic        WARN_CLEAR_I,
	// alarm outputs
	output var  logic        FAULT_OUTPUT_O,
	output var  logic        SERVO_OFF_O,
	output var  logic [7:0]  ALARM_CODE_O,
	output var  logic [15:0] DISPLAY_O,
	output var  logic        RESET_LOCKED_O,
	// history and warnings
	output var  logic        HIST_WR_O,
	output var  logic [7:0]  HIST_CODE_O,
	output var  logic [7:0]  WARN_CODE_O
);
	localparam int NT = `SDAM_NUM_TRIPS;

	// trip index to code, lower index wins
	function automatic logic [7:0] code_of(input int unsigned idx);
		case (idx)
			0:       code_of = `SDAM_ALM_PARAM_DATA;
			1:       code_of = `SDAM_ALM_PARAM_VERIFY;
			2:       code_of = `SDAM_ALM_ENC_COMM;
			3:       code_of = `SDAM_ALM_ESTOP;
			4:       code_of = `SDAM_ALM_INHIBIT;
			5:       code_of = `SDAM_ALM_INT_DEV;
			6:       code_of = `SDAM_ALM_DEV_OVF;
			7:       code_of = `SDAM_ALM_OVERSPEED;
			8:       code_of = `SDAM_ALM_OVERRUN;
			9:       code_of = `SDAM_ALM_OVERLOAD;
			10:      code_of = `SDAM_ALM_INDEX;
			11:      code_of = `SDAM_ALM_NODE_ADDR;
			12:      code_of = `SDAM_ALM_COMM;
			13:      code_of = `SDAM_ALM_SYNC_CYCLE;
			default: code_of = `SDAM_ALM_SYNC_CMD;
		endcase
	endfunction

	function automatic sdam_pkg::sdam_class_t class_of(input logic [7:0] code);
		class_of = '0;
		case (code)
			`SDAM_ALM_ENC_COMM:     class_of.power_cycle_clear_class = 1'b1;
			`SDAM_ALM_PARAM_DATA,
			`SDAM_ALM_PARAM_VERIFY: class_of = 2'b11;
			`SDAM_ALM_INHIBIT,
			`SDAM_ALM_ESTOP:        class_of.no_history = 1'b1;
			default:                class_of = '0;
		endcase
	endfunction

	function automatic logic [15:0] to_ascii(input logic [7:0] bcd);
		to_ascii = {`SDAM_ASCII_DIGIT, bcd[7:4], `SDAM_ASCII_DIGIT, bcd[3:0]};
	endfunction

	// network warning outranks overload warning
	function automatic logic [7:0] warn_code(input logic net, input logic ovl);
		warn_code = net ? `SDAM_WRN_NET : ovl ? `SDAM_WRN_OVERLOAD : `SDAM_WRN_NONE;
	endfunction

	// synchronised pins
	logic [11:0] pins_s;
	logic        estop_s, fwd_s, rev_s, index_s;
	logic [7:0]  node_s;

	sdam_sync #(.WIDTH(12)) u_sync (
		.clk_i (CLK_I),
		.rst_i (RST_I),
		.d_i   ({ESTOP_OPEN_I, FWD_TRAVEL_INHIBIT_OPEN_I, REV_TRAVEL_INHIBIT_OPEN_I,
		         INDEX_PULSE_I, NODE_ADDR_I}),
		.q_o   (pins_s)
	);
	assign {estop_s, fwd_s, rev_s, index_s, node_s} = pins_s;

	// state
	sdam_pkg::sdam_state_t state_q, state_d;
	logic [7:0]  code_q, code_d;
	logic        pr_q, pr_d;
	logic [31:0] lock_q, lock_d;
	logic        hist_wr_q, hist_wr_d;
	logic [7:0]  hist_code_q, hist_code_d;
	logic [15:0] disp_q, disp_d;
	logic [7:0]  enc_fail_q, enc_fail_d;
	logic [7:0]  rx_fail_q, rx_fail_d;
	logic        sync_seen_q, sync_seen_d;
	logic        index_prev_q;
	logic [1:0]  settle_q, settle_d;
	logic [23:0] index_cnt_q, index_cnt_d;
	logic        warn_ovl_q, warn_ovl_d, warn_net_q, warn_net_d;
	logic [NT-1:0] trip;
	logic        any_trip, any_reset, reset_ok;
	logic [7:0]  new_code;
	sdam_pkg::sdam_class_t new_cls;

	// detection
	always_comb
	begin
		trip     = '0;
		trip[0]  = PARAM_CHECK_DONE_I && PARAM_DATA_BAD_I;
		trip[1]  = PARAM_CHECK_DONE_I && PARAM_VERIFY_BAD_I;
		trip[2]  = enc_fail_q >= 8'(ENC_FAIL_LIMIT);
		trip[3]  = estop_s;
		trip[4]  = fwd_s && rev_s;
		trip[5]  = INTERNAL_DEV_CNT_I > `SDAM_INT_DEV_LIMIT;
		trip[6]  = DEVIATION_CNT_I > DEVIATION_OVERFLOW_LEVEL_I;
		trip[7]  = MOTOR_SPEED_I > OVERSPEED_DETECT_LEVEL_I;
		trip[8]  = OVERRUN_DISTANCE_I > OVERRUN_RANGE_SETTING_I;
		trip[9]  = OVERLOAD_TRIP_I;
		trip[10] = (INDEX_TIMEOUT_I != '0) && (index_cnt_q >= INDEX_TIMEOUT_I);
		// synchroniser shows 0 for two edges after reset; not a real address
		trip[11] = settle_q[1]
		           && ((node_s < `SDAM_NODE_MIN) || (node_s > `SDAM_NODE_MAX));
		trip[12] = rx_fail_q > COMM_RETRY_LIMIT_I;
		trip[13] = LINK_ACTIVE_I && CYCLE_TICK_I && !sync_seen_q;
		trip[14] = ASYNC_MODE_I && SYNC_CMD_I;
		any_trip = |trip;
		new_code = code_of(NT - 1);
		for (int i = NT - 1; i >= 0; i--)
		begin
			if (trip[i])
			begin
				new_code = code_of(i);
			end
		end
		new_cls = class_of(new_code);
	end

	// monitor counters
	always_comb
	begin
		enc_fail_d  = enc_fail_q;
		rx_fail_d   = rx_fail_q;
		sync_seen_d = sync_seen_q;
		index_cnt_d = index_cnt_q;
		settle_d    = {settle_q[0], 1'b1};
		if (ENC_COMM_OK_I)
		begin
			enc_fail_d = '0;
		end
		else if (ENC_COMM_FAIL_I && enc_fail_q != 8'hFF)
		begin
			enc_fail_d = enc_fail_q + 8'h01;
		end
		if (RX_OK_I)
		begin
			rx_fail_d = '0;
		end
		else if (RX_FAIL_I && rx_fail_q != 8'hFF)
		begin
			rx_fail_d = rx_fail_q + 8'h01;
		end
		// a frame in the tick cycle counts for the next cycle
		if (CYCLE_TICK_I || !LINK_ACTIVE_I)
		begin
			sync_seen_d = SYNC_FRAME_I;
		end
		else if (SYNC_FRAME_I)
		begin
			sync_seen_d = 1'b1;
		end
		if (index_s && !index_prev_q)
		begin
			index_cnt_d = '0;
		end
		else if (index_cnt_q != 24'hFF_FFFF)
		begin
			index_cnt_d = index_cnt_q + 24'h00_0001;
		end
	end

	// alarm latch, reset and display
	always_comb
	begin
		state_d     = state_q;
		code_d      = code_q;
		pr_d        = pr_q;
		lock_d      = (lock_q != '0) ? lock_q - 32'h1 : lock_q;
		hist_wr_d   = 1'b0;
		hist_code_d = hist_code_q;
		any_reset   = RESET_BUS_I || RESET_TOOL_I || RESET_PANEL_I;
		reset_ok    = any_reset && !pr_q && (lock_q == '0);
		case (state_q)
			sdam_pkg::SDAM_RUN:
			begin
				if (any_trip)
				begin
					state_d     = sdam_pkg::SDAM_FAULT;
					code_d      = new_code;
					pr_d        = new_cls.power_cycle_clear_class;
					hist_wr_d   = !new_cls.no_history;
					hist_code_d = new_code;
					if (new_code == `SDAM_ALM_OVERLOAD)
					begin
						lock_d = 32'(LOCK_CYCLES);
					end
				end
			end
			sdam_pkg::SDAM_FAULT:
			begin
				// code frozen here; a trip still present re-latches next cycle
				if (reset_ok)
				begin
					state_d = sdam_pkg::SDAM_RUN;
					code_d  = `SDAM_WRN_NONE;
				end
			end
			default: state_d = sdam_pkg::SDAM_RUN;
		endcase
		// warnings: set wins over clear
		warn_ovl_d = OVERLOAD_NEAR_I || (warn_ovl_q && !WARN_CLEAR_I);
		warn_net_d = NET_ERROR_I || (warn_net_q && !WARN_CLEAR_I);
		case (MPU_FAULT_I)
			`SDAM_MPU_NONE: disp_d = (state_d == sdam_pkg::SDAM_FAULT) ? to_ascii(code_d)
			                         : (warn_net_d || warn_ovl_d) ? to_ascii(warn_code(warn_net_d, warn_ovl_d))
			                         : `SDAM_DISP_BLANK;
			`SDAM_MPU_HH:   disp_d = `SDAM_DISP_HH;
			`SDAM_MPU_LHH:  disp_d = `SDAM_DISP_LHH;
			default:        disp_d = `SDAM_DISP_YY;
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			state_q      <= sdam_pkg::SDAM_RUN;
			code_q       <= '0;
			pr_q         <= 1'b0;
			lock_q       <= '0;
			hist_wr_q    <= 1'b0;
			hist_code_q  <= '0;
			disp_q       <= `SDAM_DISP_BLANK;
			enc_fail_q   <= '0;
			rx_fail_q    <= '0;
			sync_seen_q  <= 1'b1;
			index_prev_q <= 1'b0;
			settle_q     <= '0;
			index_cnt_q  <= '0;
			warn_ovl_q   <= 1'b0;
			warn_net_q   <= 1'b0;
		end
		else
		begin
			state_q      <= state_d;
			code_q       <= code_d;
			pr_q         <= pr_d;
			lock_q       <= lock_d;
			hist_wr_q    <= hist_wr_d;
			hist_code_q  <= hist_code_d;
			disp_q       <= disp_d;
			enc_fail_q   <= enc_fail_d;
			rx_fail_q    <= rx_fail_d;
			sync_seen_q  <= sync_seen_d;
			index_prev_q <= index_s;
			settle_q     <= settle_d;
			index_cnt_q  <= index_cnt_d;
			warn_ovl_q   <= warn_ovl_d;
			warn_net_q   <= warn_net_d;
		end
	end

	// processor fault also counts as a fault for the output pin
	assign FAULT_OUTPUT_O = (state_q == sdam_pkg::SDAM_RUN) && (MPU_FAULT_I == `SDAM_MPU_NONE);
	assign SERVO_OFF_O    = !FAULT_OUTPUT_O;
	assign ALARM_CODE_O   = code_q;
	assign DISPLAY_O      = disp_q;
	assign RESET_LOCKED_O = lock_q != '0;
	assign HIST_WR_O      = hist_wr_q;
	assign HIST_CODE_O    = hist_code_q;
	assign WARN_CODE_O    = warn_code(warn_net_q, warn_ovl_q);

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	trip_drops_fault_a: assert property (
		any_trip && state_q == sdam_pkg::SDAM_RUN |=> !FAULT_OUTPUT_O && SERVO_OFF_O)
		else $error("trip did not drop fault output");
	code_held_a: assert property (state_q == sdam_pkg::SDAM_FAULT && !reset_ok |=> $stable(ALARM_CODE_O) && state_q == sdam_pkg::SDAM_FAULT) else $error("alarm code changed while pending");
	pr_ignores_reset_a: assert property (state_q == sdam_pkg::SDAM_FAULT && pr_q && any_reset |=> state_q == sdam_pkg::SDAM_FAULT) else $error("power-cycle alarm was reset");
	reset_clears_a: assert property (state_q == sdam_pkg::SDAM_FAULT && !pr_q && lock_q == '0 && (RESET_BUS_I || RESET_TOOL_I || RESET_PANEL_I) |=> FAULT_OUTPUT_O || MPU_FAULT_I != `SDAM_MPU_NONE) else $error("reset did not clear alarm");
	overload_lock_a: assert property (state_q == sdam_pkg::SDAM_RUN && any_trip && new_code == `SDAM_ALM_OVERLOAD |=> RESET_LOCKED_O [*8]) else $error("overload lockout missing");
	hist_class_a: assert property (
		state_q == sdam_pkg::SDAM_RUN && any_trip
		|=> HIST_WR_O == !$past(new_cls.no_history) && HIST_CODE_O == $past(new_code))
		else $error("history write class wrong");
	estop_trips_a: assert property (
		$rose(estop_s) && !(state_q == sdam_pkg::SDAM_FAULT && reset_ok)
		|=> state_q == sdam_pkg::SDAM_FAULT)
		else $error("estop did not trip");
	inhibit_trips_a: assert property (fwd_s && rev_s && state_q == sdam_pkg::SDAM_RUN |=> ALARM_CODE_O != '0) else $error("inhibit pair did not trip");
	mpu_pattern_a: assert property (MPU_FAULT_I == `SDAM_MPU_HH |=> DISPLAY_O == `SDAM_DISP_HH) else $error("processor pattern not shown");
	warn_latch_a: assert property (OVERLOAD_NEAR_I && !NET_ERROR_I |=> WARN_CODE_O != `SDAM_WRN_NONE ##1 (WARN_CODE_O != `SDAM_WRN_NONE || $past(WARN_CLEAR_I))) else $error("warning not latched");

	ordinary_cycle_c: cover property (state_q == sdam_pkg::SDAM_RUN ##1 state_q == sdam_pkg::SDAM_FAULT && !pr_q ##[1:20] state_q == sdam_pkg::SDAM_RUN);
	power_cycle_c: cover property (state_q == sdam_pkg::SDAM_FAULT && pr_q && any_reset);
	warning_c: cover property (WARN_CODE_O == `SDAM_WRN_NET);
endmodule
`default_nettype wire

// ---- verilog/sdam_regs.svh ----
// alarm manager constants: alarm codes, display patterns, timing
`ifndef SDAM_REGS_SVH
`define SDAM_REGS_SVH

// alarm codes, two BCD digits
`define SDAM_ALM_OVERLOAD     8'h16
`define SDAM_ALM_ENC_COMM     8'h21
`define SDAM_ALM_DEV_OVF      8'h24
`define SDAM_ALM_OVERSPEED    8'h26
`define SDAM_ALM_INT_DEV      8'h29
`define SDAM_ALM_OVERRUN      8'h34
`define SDAM_ALM_PARAM_DATA   8'h36
`define SDAM_ALM_PARAM_VERIFY 8'h37
`define SDAM_ALM_INHIBIT      8'h38
`define SDAM_ALM_INDEX        8'h48
`define SDAM_ALM_NODE_ADDR    8'h82
`define SDAM_ALM_COMM         8'h83
`define SDAM_ALM_SYNC_CYCLE   8'h84
`define SDAM_ALM_ESTOP        8'h87
`define SDAM_ALM_SYNC_CMD     8'h91

// warning codes
`define SDAM_WRN_NET          8'h96
`define SDAM_WRN_OVERLOAD     8'h90
`define SDAM_WRN_NONE         8'h00

// processor fault and blank display patterns, two ASCII characters; high nibble of an ASCII digit
`define SDAM_DISP_HH          16'h4848
`define SDAM_DISP_LHH         16'h6868
`define SDAM_DISP_YY          16'h7979
`define SDAM_DISP_BLANK       16'h2020
`define SDAM_ASCII_DIGIT      4'h3

// processor fault selector values
`define SDAM_MPU_NONE         2'h0
`define SDAM_MPU_HH           2'h1
`define SDAM_MPU_LHH          2'h2

// internal deviation counter limit, two to the 27th
`define SDAM_INT_DEV_LIMIT    32'h0800_0000

// node address permitted range
`define SDAM_NODE_MIN         8'h03
`define SDAM_NODE_MAX         8'h1F

// overload reset lockout
`define SDAM_LOCK_TIME_MS     10000
`define SDAM_CLK_HZ           100000000
`define SDAM_HZ_PER_KHZ       1000

// trip vector size
`define SDAM_NUM_TRIPS        15

`endif

// ---- verilog/sdam_pkg.sv ----
// alarm manager shared types
`default_nettype none
package sdam_pkg;
	typedef enum logic [0:0]
	{
		SDAM_RUN   = 1'b0,
		SDAM_FAULT = 1'b1
	} sdam_state_t;

	typedef struct packed
	{
		logic power_cycle_clear_class;
		logic no_history;
	} sdam_class_t;
endpackage
`default_nettype wire

// ---- verilog/sdam_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sdam_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// pins and synchronised levels
	input  wire logic [WIDTH-1:0] d_i,
	output var  logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_q <= '0;
			q_o    <= '0;
		end
		else
		begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ---- verif/sdam_host_model.sv ----
// host controller stand-in: alarm resets and sync commands over the fieldbus
`timescale 1ns/10ps
`default_nettype none
module sdam_host_model (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// requests from the bench
	input  wire logic reset_req_i,
	input  wire logic slow_i,
	input  wire logic sync_req_i,
	input  wire logic async_i,
	input  wire logic allow_bad_i,
	// fieldbus side of the drive
	output var  logic reset_bus_o,
	output var  logic sync_cmd_o
);
	logic [2:0] wait_q;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wait_q      <= 3'h0;
			reset_bus_o <= 1'b0;
			sync_cmd_o  <= 1'b0;
		end
		else
		begin
			// one-cycle pulse, one cycle after the request, or four cycles after it when slow
			reset_bus_o <= (wait_q == 3'h1);
			// a real host never sends these in async mode; only on purpose here
			sync_cmd_o  <= sync_req_i && (!async_i || allow_bad_i);
			if (reset_req_i)
				wait_q <= slow_i ? 3'h4 : 3'h1;
			else if (wait_q != 3'h0)
				wait_q <= wait_q - 3'h1;
		end
	end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// bench for the alarm manager: trip table, reset classes, lockout, warnings
`timescale 1ns/10ps
`default_nettype none
`include "sdam_regs.svh"
module tb;
	typedef struct packed
	{
		logic [3:0] k;
		logic [7:0] code;
		logic       hist;
		logic       pc;
	} sdam_row_t;

	logic        clk = 1'b0;
	logic        rst, estop, fwd, rev, idx, ovl, near, pcd, pdb, pvb, encf, encok, rxf, rxok;
	logic        link, tick, frm, async, bad, sreq, rreq, slow, nerr, tool, panel, wclr;
	logic        rbus, scmd, fault, soff, lck, hwr;
	logic [1:0]  mpu;
	logic [7:0]  node, retry, code, hcode, wcode, hist_c;
	logic [15:0] spd, slvl, disp, pat;
	logic [23:0] ito;
	logic [31:0] dcnt, lvl, idev, odist, rng;
	int          n_mismatch, total_checks, hist_n;
	sdam_row_t   row;
	sdam_row_t   rows [14] = '{
		'{4'h0, 8'h24, 1'b1, 1'b0},
		'{4'h1, 8'h26, 1'b1, 1'b0},
		'{4'h2, 8'h29, 1'b1, 1'b0},
		'{4'h3, 8'h34, 1'b1, 1'b0},
		'{4'h4, 8'h87, 1'b0, 1'b0},
		'{4'h5, 8'h38, 1'b0, 1'b0},
		'{4'h6, 8'h82, 1'b1, 1'b0},
		'{4'h7, 8'h91, 1'b1, 1'b0},
		'{4'h8, 8'h36, 1'b0, 1'b1},
		'{4'h9, 8'h37, 1'b0, 1'b1},
		'{4'hA, 8'h21, 1'b1, 1'b1},
		'{4'hB, 8'h83, 1'b1, 1'b0},
		'{4'hC, 8'h84, 1'b1, 1'b0},
		'{4'hD, 8'h48, 1'b1, 1'b0}
	};

	always #5 clk = ~clk;

	sdam_alarm_mgr #(.LOCK_CYCLES(20), .ENC_FAIL_LIMIT(3)) sdam_alarm_mgr_i (
		.CLK_I(clk), .RST_I(rst), .ESTOP_OPEN_I(estop),
		.FWD_TRAVEL_INHIBIT_OPEN_I(fwd), .REV_TRAVEL_INHIBIT_OPEN_I(rev),
		.INDEX_PULSE_I(idx), .NODE_ADDR_I(node), .DEVIATION_CNT_I(dcnt),
		.DEVIATION_OVERFLOW_LEVEL_I(lvl), .MOTOR_SPEED_I(spd), .OVERSPEED_DETECT_LEVEL_I(slvl),
		.INTERNAL_DEV_CNT_I(idev), .OVERRUN_DISTANCE_I(odist), .OVERRUN_RANGE_SETTING_I(rng),
		.INDEX_TIMEOUT_I(ito), .OVERLOAD_TRIP_I(ovl), .OVERLOAD_NEAR_I(near), .MPU_FAULT_I(mpu),
		.PARAM_CHECK_DONE_I(pcd), .PARAM_DATA_BAD_I(pdb), .PARAM_VERIFY_BAD_I(pvb),
		.ENC_COMM_FAIL_I(encf), .ENC_COMM_OK_I(encok), .RX_FAIL_I(rxf), .RX_OK_I(rxok),
		.COMM_RETRY_LIMIT_I(retry), .LINK_ACTIVE_I(link), .CYCLE_TICK_I(tick),
		.SYNC_FRAME_I(frm), .ASYNC_MODE_I(async), .SYNC_CMD_I(scmd), .NET_ERROR_I(nerr),
		.RESET_BUS_I(rbus), .RESET_TOOL_I(tool), .RESET_PANEL_I(panel), .WARN_CLEAR_I(wclr),
		.FAULT_OUTPUT_O(fault), .SERVO_OFF_O(soff), .ALARM_CODE_O(code), .DISPLAY_O(disp),
		.RESET_LOCKED_O(lck), .HIST_WR_O(hwr), .HIST_CODE_O(hcode), .WARN_CODE_O(wcode)
	);

	sdam_host_model sdam_host_model_i (
		.clk_i(clk), .rst_i(rst), .reset_req_i(rreq), .slow_i(slow), .sync_req_i(sreq),
		.async_i(async), .allow_bad_i(bad), .reset_bus_o(rbus), .sync_cmd_o(scmd)
	);

	// history writes counted at the falling edge, where the one-cycle pulse has settled
	always @(negedge clk)
		if (hwr === 1'b1)
		begin
			hist_n++;
			hist_c = hcode;
		end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// benign levels; ok pulses flush the failure counters so nothing re-latches
	task calm();
		{estop, fwd, rev, idx, ovl, near, pcd, pdb, pvb, encf, rxf, link, tick, frm} = '0;
		{async, bad, sreq, rreq, slow, nerr, tool, panel, wclr, mpu, dcnt, spd, idev, odist, ito} = '0;
		{lvl, slvl, rng, node, retry} = {32'h0000_0100, 16'h0200, 32'h0000_0040, 8'h05, 8'h02};
		{encok, rxok} = 2'b11;
		@(negedge clk) {encok, rxok} = 2'b00;
	endtask

	task reset_dut();
		rst = 1'b1;
		hist_n = 0;
		hist_c = 8'h00;
		calm();
		cyc(10);
		rst = 1'b0;
		cyc(4);
	endtask

	task pulses(input int s, input int n);
		repeat (n)
		begin
			{encf, rxf, tick, idx} = 4'h8 >> s;
			@(negedge clk) {encf, rxf, tick, idx} = 4'h0;
			@(negedge clk);
		end
	endtask

	task trip(input logic [3:0] k);
		case (k)
			4'h0: dcnt = 32'h0000_0101;
			4'h1: spd = 16'h0201;
			4'h2: idev = 32'h0800_0001;
			4'h3: odist = 32'h0000_0041;
			4'h4: estop = 1'b1;
			4'h5: {fwd, rev} = 2'b11;
			4'h6: node = 8'h20;
			4'h7: {async, bad, sreq} = 3'b111;
			4'h8: {pcd, pdb} = 2'b11;
			4'h9: {pcd, pvb} = 2'b11;
			4'hA: pulses(0, 3);
			4'hB: pulses(1, 3);
			4'hC:
			begin
				link = 1'b1;
				pulses(2, 2);
			end
			default:
			begin
				ito = 24'h00_0010;
				pulses(3, 1);
				cyc(20);
			end
		endcase
		@(negedge clk) {pcd, sreq} = 2'b00;
	endtask

	task rst_req(input int s, input logic sl);
		slow = sl;
		rreq = (s == 0);
		tool = (s == 1);
		panel = (s == 2);
		@(negedge clk) {rreq, tool, panel} = 3'h0;
	endtask

	initial
	begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end

	initial
	begin
		for (int r = 0; r < 14; r++)
		begin
			row = rows[r];
			reset_dut();
			trip(row.k);
			cyc(6);
			chk({fault, soff}, 2'b01);
			chk({code, disp}, {row.code, 4'h3, row.code[7:4], 4'h3, row.code[3:0]});
			chk({hist_n[3:0], hist_c}, {3'h0, row.hist, row.hist ? row.code : 8'h00});
			calm();
			cyc(3);
			rst_req(r % 3, r > 6);
			cyc(7);
			chk(code, row.pc ? row.code : 8'h00);
		end
		// values at their limits and legal sync traffic must stay quiet
		reset_dut();
		chk({code, fault, disp}, {8'h00, 1'b1, `SDAM_DISP_BLANK});
		{dcnt, spd, idev, odist} = {32'h0000_0100, 16'h0200, 32'h0800_0000, 32'h0000_0040};
		{link, sreq} = 2'b11;
		repeat (2)
		begin
			frm = 1'b1;
			@(negedge clk) {frm, sreq} = 2'b00;
			pulses(2, 1);
		end
		cyc(3);
		chk({code, fault}, {8'h00, 1'b1});
		{dcnt, spd} = {32'h0000_0101, 16'h0201};
		cyc(3);
		estop = 1'b1;
		cyc(5);
		chk({code, hist_n[3:0]}, {8'h24, 4'h1});
		reset_dut();
		ovl = 1'b1;
		@(negedge clk) ovl = 1'b0;
		cyc(2);
		chk({code, lck, hist_c}, {8'h16, 1'b1, 8'h16});
		rst_req(2, 1'b0);
		cyc(2);
		chk(code, 8'h16);
		cyc(20);
		chk(lck, 1'b0);
		rst_req(1, 1'b0);
		cyc(2);
		chk(code, 8'h00);
		nerr = 1'b1;
		@(negedge clk) {nerr, near} = 2'b01;
		@(negedge clk) near = 1'b0;
		cyc(2);
		chk({wcode, disp, fault}, {8'h96, 16'h3936, 1'b1});
		wclr = 1'b1;
		@(negedge clk) {wclr, near} = 2'b01;
		@(negedge clk) near = 1'b0;
		cyc(2);
		chk(wcode, 8'h90);
		for (int i = 1; i < 4; i++)
		begin
			mpu = i[1:0];
			pat = (i == 1) ? `SDAM_DISP_HH : (i == 2) ? `SDAM_DISP_LHH : `SDAM_DISP_YY;
			cyc(2);
			chk({disp, fault}, {pat, 1'b0});
		end
		stop_test();
	end
endmodule
`default_nettype wire
